// ### design/fsr_regs.sv
// FIFO data port, fill count, threshold and status registers
// Summary of operation
// R01: Address 02h reads and writes bytes of one shared 64-byte FIFO.
// R02: Seven-bit fill count, host write adds one, host read subtracts one.
// R03: Link code 000 idle, 001 frame start, 010 payload, 011 frame end.
// R04: Link code 100 rx turn on/off, 101 guard wait, 110 listen, 111 receive.
// R05: Main status bit 3 set when any enabled interrupt source requests.
// R06: Main status bit 2 set when any fault bit is set.
// R07: Near-full alert when 64 minus fill count is at most threshold.
// R08: Near-empty alert when fill count is at most threshold.
// R09: Auxiliary bit 7 shows the timer running.
// R10: Auxiliary bit 6 shows nonvolatile programming finished.
// R11: Auxiliary bit 5 shows checksum calculation finished.
// R12: Auxiliary bits 2..0 give valid bits of last byte, zero means eight.
// R13: Six-bit threshold held in bits 5..0 of register 29h.
// R14: Host writes to read-only status and count registers are ignored.
`default_nettype none

module fsr_regs
   import fsr_pkg::*;
(
   // Clock and reset
   input  wire logic                   clk_i,
   input  wire logic                   resetn_i,
   input  wire logic                   ce_i,
   // Host register port
   input  wire logic [5:0]             addr_i,
   input  wire logic                   wr_i,
   input  wire logic                   rd_i,
   input  wire logic [7:0]             wdata_i,
   output logic      [7:0]             rdata_o,
   output logic                        rvalid_o,
   // Modem side of the FIFO
   input  wire logic                   core_push_i,
   input  wire logic [7:0]             core_wdata_i,
   output logic                        core_push_ack_o,
   input  wire logic                   core_pop_i,
   output logic      [7:0]             core_rdata_o,
   output logic                        core_rvalid_o,
   // Status sources
   input  wire fsr_pkg::fsr_modem_type modem_state_i,
   input  wire logic [5:0]             irq_request_i,
   input  wire logic [5:0]             irq_mask_reg_i,
   input  wire logic [7:0]             fault_bits_reg_i,
   input  wire logic                   timer_active_i,
   input  wire logic                   eeprom_write_done_i,
   input  wire logic                   checksum_done_i,
   input  wire logic [2:0]             rx_final_valid_bits_i,
   // Level outputs
   output logic      [6:0]             fifo_fill_count_o,
   output logic                        near_full_alert_o,
   output logic                        near_empty_alert_o
);

   import fsr_pkg::*;

   // ==========================================================
   // State
   logic [FIFO_AW-1:0] wr_ptr_ff;
   logic [FIFO_AW-1:0] rd_ptr_ff;
   logic [COUNT_W-1:0] count_ff;
   logic [THR_W-1:0]   thr_ff;
   logic               rd_pend_ff;
   logic               rd_fifo_ff;
   logic               core_pend_ff;
   logic [7:0]         snap_ff;
   logic [7:0]         mem_q;

   // ==========================================================
   // Decode
   wire hit_fifo  = (addr_i == ADR_FIFO_PORT);
   wire hit_main  = (addr_i == ADR_MAIN_STATUS);
   wire hit_fill  = (addr_i == ADR_FILL_COUNT);
   wire hit_aux   = (addr_i == ADR_AUX_STATUS);
   wire hit_thr   = (addr_i == ADR_THRESHOLD);

   wire fifo_full  = (count_ff == FIFO_SIZE);
   wire fifo_empty = (count_ff == 7'h00);

   // Host wins the single port; the modem retries on a missing ack
   wire host_wr_req = wr_i && hit_fifo;
   wire host_rd_req = rd_i && hit_fifo;
   wire host_push   = host_wr_req && !fifo_full;                        // R01
   wire host_pop    = host_rd_req && !fifo_empty;                       // R01
   wire core_push   = core_push_i && !host_wr_req && !fifo_full;
   wire core_pop    = core_pop_i && !host_rd_req && !fifo_empty;
   wire do_push     = host_push || core_push;
   wire do_pop      = host_pop || core_pop;
   wire [7:0] push_data = host_wr_req ? wdata_i : core_wdata_i;

   wire [COUNT_W-1:0] nxt_count = count_ff
                                + {6'h00, do_push}
                                - {6'h00, do_pop};                      // R02

   // ==========================================================
   // Status derivation
   logic [2:0] link_code;
   always_comb
   begin
      case (modem_state_i)
         MODEM_IDLE:             link_code = LSC_IDLE;                  // R03
         MODEM_SEND_FRAME_START: link_code = LSC_TX_START;              // R03
         MODEM_SEND_PAYLOAD:     link_code = LSC_TX_PAYLOAD;            // R03
         MODEM_SEND_FRAME_END:   link_code = LSC_TX_END;                // R03
         MODEM_RX_TURN_ON:       link_code = LSC_RX_TURN;               // R04
         MODEM_RX_TURN_OFF:      link_code = LSC_RX_TURN;               // R04
         MODEM_RX_GUARD_WAIT:    link_code = LSC_RX_GUARD;              // R04
         MODEM_RX_LISTENING:     link_code = LSC_RX_LISTEN;             // R04
         MODEM_RX_RECEIVING:     link_code = LSC_RX_DATA;               // R04
         default:                link_code = LSC_IDLE;
      endcase
   end

   wire any_irq    = |(irq_request_i & irq_mask_reg_i);                 // R05
   wire err_sum    = |fault_bits_reg_i;                                 // R06
   // 64 - count never underflows since count stays at or below 64
   wire [COUNT_W-1:0] free_slots = FIFO_SIZE - count_ff;
   wire near_full  = (free_slots <= {1'b0, thr_ff});                    // R07 R13
   wire near_empty = (count_ff <= {1'b0, thr_ff});                      // R08 R13

   wire [7:0] main_word;
   assign main_word[7]                       = 1'b0;
   assign main_word[MS_LINK_LSB +: 3]        = link_code;               // R03 R04
   assign main_word[MS_IRQ]                  = any_irq;                 // R05
   assign main_word[MS_ERROR]                = err_sum;                 // R06
   assign main_word[MS_HIGH_ALERT]           = near_full;               // R07
   assign main_word[MS_LOW_ALERT]            = near_empty;              // R08

   wire [7:0] aux_word;
   assign aux_word[AS_TIMER]                 = timer_active_i;          // R09
   assign aux_word[AS_EEPROM]                = eeprom_write_done_i;     // R10
   assign aux_word[AS_CHECKSUM]              = checksum_done_i;         // R11
   assign aux_word[4:3]                      = 2'b00;
   assign aux_word[AS_LAST_LSB +: 3]         = rx_final_valid_bits_i;   // R12

   // Unmapped and empty-FIFO reads answer zero
   wire [7:0] rd_mux = hit_main ? main_word
                     : hit_fill ? {1'b0, count_ff}                      // R02
                     : hit_aux  ? aux_word
                     : hit_thr  ? {2'b00, thr_ff}                       // R13
                     : 8'h00;

   // ==========================================================
   // Storage
   fsr_fifo_mem
   #(
      .W     (8),
      .DEPTH (FIFO_DEPTH),
      .AW    (FIFO_AW)
   )
   u_mem
   (
      .clk_i    (clk_i),
      .resetn_i (resetn_i),
      .ce_i     (ce_i),
      .we_i     (do_push),
      .waddr_i  (wr_ptr_ff),
      .wdata_i  (push_data),
      .re_i     (do_pop),
      .raddr_i  (rd_ptr_ff),
      .rdata_o  (mem_q)
   );

   // ==========================================================
   // FIFO pointers and count
   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         count_ff  <= '0;
      end
      else if (ce_i)
      begin
         wr_ptr_ff <= wr_ptr_ff + FIFO_AW'(do_push);
         rd_ptr_ff <= rd_ptr_ff + FIFO_AW'(do_pop);
         count_ff  <= nxt_count;                                        // R02
      end
   end

   // Besides the FIFO port only the threshold is writable; status and count writes fall through
   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         thr_ff <= THRESHOLD_RST;
      end
      else if (ce_i && wr_i && hit_thr)
      begin
         thr_ff <= wdata_i[THR_W-1:0];                                  // R13 R14
      end
   end

   // ==========================================================
   // Read pipeline, two cycles so data leaves a flop
   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         rd_pend_ff   <= 1'b0;
         rd_fifo_ff   <= 1'b0;
         core_pend_ff <= 1'b0;
         snap_ff      <= 8'h00;
      end
      else if (ce_i)
      begin
         rd_pend_ff   <= rd_i;
         rd_fifo_ff   <= host_pop;
         core_pend_ff <= core_pop;
         snap_ff      <= rd_mux;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         rdata_o            <= 8'h00;
         rvalid_o           <= 1'b0;
         core_rdata_o       <= 8'h00;
         core_rvalid_o      <= 1'b0;
         core_push_ack_o    <= 1'b0;
         fifo_fill_count_o  <= 7'h00;
         near_full_alert_o  <= 1'b0;
         near_empty_alert_o <= 1'b1;
      end
      else if (ce_i)
      begin
         rdata_o            <= rd_fifo_ff ? mem_q : snap_ff;            // R01
         rvalid_o           <= rd_pend_ff;
         core_rdata_o       <= core_pend_ff ? mem_q : core_rdata_o;
         core_rvalid_o      <= core_pend_ff;
         core_push_ack_o    <= core_push;
         fifo_fill_count_o  <= nxt_count;
         near_full_alert_o  <= near_full;
         near_empty_alert_o <= near_empty;
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!resetn_i || !ce_i);

   a_fill_inc: assert property (host_push && !do_pop |=> count_ff == $past(count_ff) + 7'h01) // R02
      else $error("fill count did not rise on host write");
   a_fill_dec: assert property (host_pop && !do_push |=> count_ff == $past(count_ff) - 7'h01) // R02
      else $error("fill count did not fall on host read");
   a_fill_bound: assert property (rd_i && hit_fill |-> ##2 rdata_o[7] == 1'b0 && count_ff <= FIFO_SIZE) // R02
      else $error("fill count top bit or bound broken");
   a_near_full_read: assert property (rd_i && hit_main
      |-> ##2 rdata_o[MS_HIGH_ALERT] == ((7'h40 - $past(count_ff, 2)) <= {1'b0, $past(thr_ff, 2)})) // R07
      else $error("near full alert wrong");
   a_near_empty_read: assert property (rd_i && hit_main
      |-> ##2 rdata_o[MS_LOW_ALERT] == ($past(count_ff, 2) <= {1'b0, $past(thr_ff, 2)})) // R08
      else $error("near empty alert wrong");
   a_err_irq_read: assert property (rd_i && hit_main |-> ##2 rdata_o[MS_ERROR] == |$past(fault_bits_reg_i, 2)
      && rdata_o[MS_IRQ] == |($past(irq_request_i, 2) & $past(irq_mask_reg_i, 2))) // R05 R06
      else $error("error or interrupt summary wrong");
   a_link_turn: assert property (rd_i && hit_main && (modem_state_i == MODEM_RX_TURN_OFF
      || modem_state_i == MODEM_RX_TURN_ON) |-> ##2 rdata_o[6:4] == 3'h4) // R04
      else $error("turn state code wrong");
   a_link_payload: assert property (rd_i && hit_main && modem_state_i == MODEM_SEND_PAYLOAD
      |-> ##2 rdata_o[6:4] == 3'h2) // R03
      else $error("payload state code wrong");
   a_aux_read: assert property (rd_i && hit_aux |-> ##2 rdata_o == {$past(timer_active_i, 2),
      $past(eeprom_write_done_i, 2), $past(checksum_done_i, 2), 2'b00, $past(rx_final_valid_bits_i, 2)}) // R09 R10 R11 R12
      else $error("auxiliary status wrong");
   a_ro_write: assert property (wr_i && (hit_fill || hit_main || hit_aux) && !core_push_i && !core_pop_i
      |=> count_ff == $past(count_ff) && thr_ff == $past(thr_ff)) // R14
      else $error("read-only write changed state");
   a_thr_write: assert property (wr_i && hit_thr |=> thr_ff == $past(wdata_i[5:0])) // R13
      else $error("threshold not written");
   // Compare against the stored byte, not the read register, so a broken read path shows
   a_fifo_data: assert property (host_pop |-> ##2 rvalid_o && rdata_o == $past(u_mem.mem_ff[rd_ptr_ff], 2)) // R01
      else $error("fifo read lost");

   // ==========================================================
   // Refusals, output copies and further link codes
   a_full_refuse: assert property (host_wr_req && fifo_full && !do_pop |=> count_ff == FIFO_SIZE) // R01
      else $error("write to full fifo was taken");
   a_empty_read: assert property (host_rd_req && fifo_empty |-> ##2 rvalid_o && rdata_o == 8'h00) // R01
      else $error("read of empty fifo returned data");
   a_count_limit: assert property (count_ff <= FIFO_SIZE) // R02
      else $error("fill count above fifo size");
   a_count_out: assert property (fifo_fill_count_o == count_ff) // R02
      else $error("fill count output differs from counter");
   a_push_ack: assert property (core_push |=> core_push_ack_o) // R01
      else $error("accepted modem push not acknowledged");
   a_alert_out: assert property ( // R07 R08
      1'b1 |=> near_full_alert_o == $past(near_full) && near_empty_alert_o == $past(near_empty))
      else $error("alert outputs do not follow the comparisons");
   a_link_start: assert property ( // R03
      rd_i && hit_main && modem_state_i == MODEM_SEND_FRAME_START |-> ##2 rdata_o[6:4] == 3'h1)
      else $error("frame start state code wrong");
   a_link_listen: assert property ( // R04
      rd_i && hit_main && modem_state_i == MODEM_RX_LISTENING |-> ##2 rdata_o[6:4] == 3'h6)
      else $error("listen state code wrong");

endmodule : fsr_regs

`default_nettype wire

// ### design/fsr_pkg.sv
// Constants and types shared by the FIFO and status register bank
`default_nettype none

package fsr_pkg;

   // ==========================================================
   // Register addresses
   localparam logic [5:0] ADR_FIFO_PORT   = 6'h02;
   localparam logic [5:0] ADR_MAIN_STATUS = 6'h03;
   localparam logic [5:0] ADR_FILL_COUNT  = 6'h04;
   localparam logic [5:0] ADR_AUX_STATUS  = 6'h05;
   localparam logic [5:0] ADR_THRESHOLD   = 6'h29;

   // ==========================================================
   // Sizes
   localparam int          FIFO_DEPTH = 64;
   localparam int          FIFO_AW    = 6;
   localparam int          COUNT_W    = 7;
   localparam int          THR_W      = 6;
   localparam int          IRQ_SRC_N  = 6;
   localparam logic [6:0]  FIFO_SIZE  = 7'h40;

   // ==========================================================
   // Field positions, main status
   localparam int MS_LOW_ALERT  = 0;
   localparam int MS_HIGH_ALERT = 1;
   localparam int MS_ERROR      = 2;
   localparam int MS_IRQ        = 3;
   localparam int MS_LINK_LSB   = 4;

   // ==========================================================
   // Field positions, auxiliary status
   localparam int AS_LAST_LSB   = 0;
   localparam int AS_CHECKSUM   = 5;
   localparam int AS_EEPROM     = 6;
   localparam int AS_TIMER      = 7;

   // ==========================================================
   // Reset values
   localparam logic [5:0] THRESHOLD_RST  = 6'h08;
   localparam logic [7:0] MAIN_RST       = 8'h05;
   localparam logic [7:0] FILL_RST       = 8'h00;
   localparam logic [7:0] AUX_RST        = 8'h60;

   // ==========================================================
   // Link state codes
   localparam logic [2:0] LSC_IDLE       = 3'h0;
   localparam logic [2:0] LSC_TX_START   = 3'h1;
   localparam logic [2:0] LSC_TX_PAYLOAD = 3'h2;
   localparam logic [2:0] LSC_TX_END     = 3'h3;
   localparam logic [2:0] LSC_RX_TURN    = 3'h4;
   localparam logic [2:0] LSC_RX_GUARD   = 3'h5;
   localparam logic [2:0] LSC_RX_LISTEN  = 3'h6;
   localparam logic [2:0] LSC_RX_DATA    = 3'h7;

   // Modem sequencer states reported by the RF side
   typedef enum logic [3:0]
   {
      MODEM_IDLE,
      MODEM_SEND_FRAME_START,
      MODEM_SEND_PAYLOAD,
      MODEM_SEND_FRAME_END,
      MODEM_RX_TURN_ON,
      MODEM_RX_TURN_OFF,
      MODEM_RX_GUARD_WAIT,
      MODEM_RX_LISTENING,
      MODEM_RX_RECEIVING
   } fsr_modem_type;

endpackage : fsr_pkg

`default_nettype wire

// ### design/fsr_fifo_mem.sv
// Byte storage of the shared FIFO, registered read data
`default_nettype none

module fsr_fifo_mem
#(
   parameter int W     = 8,
   parameter int DEPTH = 64,
   parameter int AW    = 6
)
(
   // Clock and control
   input  wire logic          clk_i,
   input  wire logic          resetn_i,
   input  wire logic          ce_i,
   // Write port
   input  wire logic          we_i,
   input  wire logic [AW-1:0] waddr_i,
   input  wire logic [W-1:0]  wdata_i,
   // Read port
   input  wire logic          re_i,
   input  wire logic [AW-1:0] raddr_i,
   output logic      [W-1:0]  rdata_o
);

   logic [W-1:0] mem_ff [DEPTH];

   // ==========================================================
   // Storage, no reset on the array
   always_ff @(posedge clk_i)
   begin
      if (ce_i && we_i)
      begin
         mem_ff[waddr_i] <= wdata_i;
      end
   end

   // ==========================================================
   // Read register
   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         rdata_o <= '0;
      end
      else if (ce_i && re_i)
      begin
         rdata_o <= mem_ff[raddr_i];
      end
   end

endmodule : fsr_fifo_mem

`default_nettype wire

// ### bench/fsr_host_model.sv
// Host processor model on the parallel register port
`default_nettype none

module fsr_host_model
   import fsr_pkg::*;
(
   // Clock
   input  wire logic       clk_i,
   // Answer from the device
   input  wire logic [7:0] rdata_i,
   input  wire logic       rvalid_i,
   // Request to the device
   output var  logic [5:0] addr_o,
   output var  logic       wr_o,
   output var  logic       rd_o,
   output var  logic [7:0] wdata_o
);
   timeunit 1ns;
   timeprecision 100ps;

   initial
   begin
      addr_o  = 6'h00;
      wr_o    = 1'b0;
      rd_o    = 1'b0;
      wdata_o = 8'h00;
   end

   // ==========================================================
   // Bus cycles; released lines show inverted values, not stale ones
   task automatic write_reg(input logic [5:0] a, input logic [7:0] d);
      @(posedge clk_i);
      #1;
      addr_o  = a;
      wdata_o = d;
      wr_o    = 1'b1;
      @(posedge clk_i);
      #1;
      wr_o    = 1'b0;
      addr_o  = ~a;
      wdata_o = ~d;
   endtask : write_reg

   task automatic read_reg(input logic [5:0] a, output logic [7:0] d);
      d = 8'hXX;
      @(posedge clk_i);
      #1;
      addr_o = a;
      rd_o   = 1'b1;
      @(posedge clk_i);
      #1;
      rd_o   = 1'b0;
      addr_o = ~a;
      for (int n = 0; n < 4; n++)
      begin
         @(posedge clk_i);
         #1;
         if (rvalid_i === 1'b1)
         begin
            d = rdata_i;
            break;
         end
      end
   endtask : read_reg

   task automatic set_threshold(input logic [5:0] t);
      write_reg(ADR_THRESHOLD, {2'b00, t});
   endtask : set_threshold

endmodule : fsr_host_model

`default_nettype wire

// ### bench/tb_fifo_and_status_registers.sv
// Self-checking testbench for the FIFO and status register bank
`default_nettype none

module tb_fifo_and_status_registers
   import fsr_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic          clk_i = 1'b0;
   logic          resetn_i = 1'b0;
   logic [5:0]    addr;
   logic          wr, rd;
   logic [7:0]    wdata, rdata;
   logic          rvalid;
   logic          core_push_i = 1'b0, core_pop_i = 1'b0;
   logic [7:0]    core_wdata_i = 8'h00;
   logic          core_push_ack_o, core_rvalid_o;
   logic [7:0]    core_rdata_o;
   fsr_modem_type modem_state_i = MODEM_IDLE;
   logic [5:0]    irq_request_i = 6'h00, irq_mask_reg_i = 6'h00;
   // Main status resets to 05h, so a fault flag stands at reset
   logic [7:0]    fault_bits_reg_i = 8'h01;
   logic          ce_i = 1'b1;
   logic          timer_active_i = 1'b0, eeprom_write_done_i = 1'b1, checksum_done_i = 1'b1;
   logic [2:0]    rx_final_valid_bits_i = 3'h0;
   logic [6:0]    fifo_fill_count_o;
   logic          near_full_alert_o, near_empty_alert_o;
   int            bad_count = 0;
   int            num_checks = 0;

   always #2.5 clk_i = ~clk_i;

   fsr_regs uut (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i), .addr_i(addr), .wr_i(wr), .rd_i(rd),
      .wdata_i(wdata), .rdata_o(rdata), .rvalid_o(rvalid), .core_push_i(core_push_i),
      .core_wdata_i(core_wdata_i), .core_push_ack_o(core_push_ack_o), .core_pop_i(core_pop_i),
      .core_rdata_o(core_rdata_o), .core_rvalid_o(core_rvalid_o), .modem_state_i(modem_state_i),
      .irq_request_i(irq_request_i), .irq_mask_reg_i(irq_mask_reg_i), .fault_bits_reg_i(fault_bits_reg_i),
      .timer_active_i(timer_active_i), .eeprom_write_done_i(eeprom_write_done_i),
      .checksum_done_i(checksum_done_i), .rx_final_valid_bits_i(rx_final_valid_bits_i),
      .fifo_fill_count_o(fifo_fill_count_o), .near_full_alert_o(near_full_alert_o),
      .near_empty_alert_o(near_empty_alert_o));

   fsr_host_model host (.clk_i(clk_i), .rdata_i(rdata), .rvalid_i(rvalid), .addr_o(addr), .wr_o(wr),
      .rd_o(rd), .wdata_o(wdata));

   // ==========================================================
   // Checking helpers
   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task automatic chk_reg(input logic [5:0] a, input logic [7:0] exp, input string name);
      logic [7:0] v;
      host.read_reg(a, v);
      chk(name, v, exp);
   endtask : chk_reg

   // Alerts trail the count by a cycle, so let both settle
   task automatic chk_level(input int n);
      repeat (2) @(posedge clk_i);
      #1;
      chk("fill count", {1'b0, fifo_fill_count_o}, n[7:0]);
      chk("near full", {7'h00, near_full_alert_o}, {7'h00, (64 - n) <= 4});
      chk("near empty", {7'h00, near_empty_alert_o}, {7'h00, n <= 4});
   endtask : chk_level

   // ==========================================================
   // Scenarios
   task automatic t_reset_and_ro;
      logic [5:0] ro_adr [4] = '{ADR_MAIN_STATUS, ADR_FILL_COUNT, ADR_AUX_STATUS, 6'h07};
      chk_reg(ADR_MAIN_STATUS, MAIN_RST, "main status");
      chk_reg(ADR_FILL_COUNT, FILL_RST, "fill count reg");
      chk_reg(ADR_AUX_STATUS, AUX_RST, "aux status");
      foreach (ro_adr[i])
         host.write_reg(ro_adr[i], 8'hFF);
      chk_reg(ADR_MAIN_STATUS, MAIN_RST, "main status ro");
      chk_reg(ADR_FILL_COUNT, FILL_RST, "fill ro");
      chk_reg(ADR_AUX_STATUS, AUX_RST, "aux ro");
      chk_reg(6'h07, 8'h00, "unmapped");
   endtask : t_reset_and_ro

   task automatic t_fill_drain;
      logic [7:0] v;
      chk_reg(ADR_THRESHOLD, {2'b00, THRESHOLD_RST}, "threshold rst");
      host.write_reg(ADR_THRESHOLD, 8'hFF);
      chk_reg(ADR_THRESHOLD, 8'h3F, "threshold width");
      host.set_threshold(6'h04);
      for (int i = 1; i <= 64; i++)
      begin
         host.write_reg(ADR_FIFO_PORT, i[7:0]);
         chk_level(i);
      end
      host.write_reg(ADR_FIFO_PORT, 8'hEE);
      chk_reg(ADR_FILL_COUNT, 8'h40, "full count");
      for (int i = 1; i <= 64; i++)
      begin
         host.read_reg(ADR_FIFO_PORT, v);
         chk("fifo byte", v, i[7:0]);
         chk_level(64 - i);
      end
      chk_reg(ADR_FIFO_PORT, 8'h00, "empty read");
      chk_reg(ADR_FILL_COUNT, 8'h00, "empty count");
   endtask : t_fill_drain

   task automatic t_link_codes;
      logic [7:0] v;
      for (int i = 0; i < 9; i++)
      begin
         modem_state_i = fsr_modem_type'(i);
         host.read_reg(ADR_MAIN_STATUS, v);
         chk("link code", {5'h00, v[6:4]}, (i < 5) ? i[7:0] : 8'(i - 1));
      end
      modem_state_i = MODEM_IDLE;
   endtask : t_link_codes

   task automatic t_flags;
      logic [7:0] v;
      logic [5:0] req [5] = '{6'h00, 6'h01, 6'h01, 6'h20, 6'h3E};
      logic [5:0] msk [5] = '{6'h3F, 6'h00, 6'h01, 6'h20, 6'h01};
      logic [7:0] flt [3] = '{8'h00, 8'h80, 8'h01};
      for (int i = 0; i < 5; i++)
      begin
         irq_request_i  = req[i];
         irq_mask_reg_i = msk[i];
         host.read_reg(ADR_MAIN_STATUS, v);
         chk("irq", {7'h00, v[3]}, {7'h00, |(req[i] & msk[i])});
      end
      for (int i = 0; i < 3; i++)
      begin
         fault_bits_reg_i = flt[i];
         host.read_reg(ADR_MAIN_STATUS, v);
         chk("error", {7'h00, v[2]}, {7'h00, flt[i] != 8'h00});
      end
      {timer_active_i, eeprom_write_done_i, checksum_done_i, rx_final_valid_bits_i} = 6'h25;
      chk_reg(ADR_AUX_STATUS, 8'h85, "aux a");
      {timer_active_i, eeprom_write_done_i, checksum_done_i, rx_final_valid_bits_i} = 6'h37;
      chk_reg(ADR_AUX_STATUS, 8'hC7, "aux b");
   endtask : t_flags

   // Host and modem share one queue of bytes
   task automatic t_shared;
      host.write_reg(ADR_FIFO_PORT, 8'hA1);
      host.write_reg(ADR_FIFO_PORT, 8'hB2);
      @(posedge clk_i);
      #1;
      core_pop_i = 1'b1;
      @(posedge clk_i);
      #1;
      core_pop_i = 1'b0;
      @(posedge clk_i);
      #1;
      chk("pop valid", {7'h00, core_rvalid_o}, 8'h01);
      chk("pop data", core_rdata_o, 8'hA1);
      core_push_i  = 1'b1;
      core_wdata_i = 8'hC3;
      @(posedge clk_i);
      #1;
      core_push_i  = 1'b0;
      core_wdata_i = 8'h3C;
      chk("push ack", {7'h00, core_push_ack_o}, 8'h01);
      chk_reg(ADR_FIFO_PORT, 8'hB2, "shared b");
      chk_reg(ADR_FIFO_PORT, 8'hC3, "shared c");
      chk_reg(ADR_FILL_COUNT, 8'h00, "shared count");
   endtask : t_shared

   // Writes while the clock enable is low must leave no trace
   task automatic t_freeze;
      ce_i = 1'b0;
      host.write_reg(ADR_FIFO_PORT, 8'h5A);
      host.write_reg(ADR_THRESHOLD, 8'h11);
      ce_i = 1'b1;
      chk_reg(ADR_FILL_COUNT, 8'h00, "frozen count");
      chk_reg(ADR_THRESHOLD, 8'h04, "frozen threshold");
   endtask : t_freeze

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : report_and_stop

   initial
   begin
      repeat (8) @(posedge clk_i);
      #1;
      resetn_i = 1'b1;
      t_reset_and_ro();
      t_fill_drain();
      t_link_codes();
      t_flags();
      t_shared();
      t_freeze();
      report_and_stop();
   end

   initial
   begin
      #100000;
      bad_count++;
      report_and_stop();
   end

endmodule : tb_fifo_and_status_registers

`default_nettype wire
